// ---- logic/ppm_port_ctrl.v ----
// Purpose: port pin mode control for ports 1 to 7, latch and pin read control for ports 2 to 7
// Assumes: one clock CORE_CLK at 250 MHz, async active-high RST
// Notes: pin inputs pass four flops; outputs are all registered
`include "ppm_defs.vh"
module ppm_port_ctrl (
   // clock and reset
   input wire CORE_CLK,
   input wire RST,
   // register port
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   input wire REG_RMW,
   input wire REG_BIT_WR,
   input wire [2:0] REG_BIT_SEL,
   input wire PAGE_F,
   output reg [7:0] REG_RDATA,
   // crossbar and peripheral overrides
   input wire [15:0] XBAR_P2_P3_ALLOC,
   input wire [15:0] PERIPH_P2_P3_OUT,
   input wire [15:0] PERIPH_FORCE_OD,
   // external memory interface
   input wire EMIF_ACTIVE,
   input wire EMIF_MUXED,
   input wire [15:0] EMIF_ADDR,
   input wire [7:0] EMIF_DATA,
   input wire EMIF_DATA_OE,
   // pins of ports 1 to 7
   input wire [55:0] PIN_IN,
   output reg [55:0] PIN_OUT,
   output reg [55:0] PIN_OE_N,
   output reg [55:0] PIN_PULLUP_EN,
   output reg [7:0] P1_ANALOG_SEL
);
   reg [7:0] p2_latch_reg;
   reg [7:0] p3_latch_reg;
   reg [7:0] p4_latch_reg;
   reg [7:0] p5_latch_reg;
   reg [7:0] p6_latch_reg;
   reg [7:0] p7_latch_reg;
   reg [7:0] p1_drive_reg;
   reg [7:0] p2_drive_reg;
   reg [7:0] p3_drive_reg;
   reg [7:0] p4_drive_reg;
   reg [7:0] p5_drive_reg;
   reg [7:0] p6_drive_reg;
   reg [7:0] p7_drive_reg;
   reg [7:0] p1_inpath_reg;
   reg [7:0] p2_inpath_reg;
   reg [7:0] p3_inpath_reg;
   reg [7:0] ctrl_reg;
   reg [7:0] rdata_next;
   reg [55:0] drv_val;
   reg [55:0] od_mode;
   reg [55:0] drive_low;
   reg [55:0] oe_n_next;
   reg [55:0] pu_next;
   reg [7:0] p2_src;
   reg [7:0] p3_src;
   wire [55:0] pin_val;
   wire [23:0] inpath = {p3_inpath_reg, p2_inpath_reg, p1_inpath_reg};
   wire [55:0] dig_en = {32'hFFFF_FFFF, inpath};
   wire [55:0] pin_read = pin_val & dig_en;
   integer i;

   // value to store: whole byte or one bit merged into the old value
   function [7:0] merge;
      input [7:0] old;
      input [7:0] d;
      input bitw;
      input [2:0] sel;
      reg [7:0] m;
      begin
         m = old;
         m[sel] = d[0];
         merge = bitw ? m : d;
      end
   endfunction

   // one settling stage per port; reads trail a pin change by four edges
   ppm_sync #(
      .W(8)
   ) p1_sync_inst (
      .clk(CORE_CLK),
      .rst(RST),
      .raw(PIN_IN[7:0]),
      .level_reg(pin_val[7:0])
   );

   ppm_sync #(
      .W(8)
   ) p2_sync_inst (
      .clk(CORE_CLK),
      .rst(RST),
      .raw(PIN_IN[15:8]),
      .level_reg(pin_val[15:8])
   );

   ppm_sync #(
      .W(8)
   ) p3_sync_inst (
      .clk(CORE_CLK),
      .rst(RST),
      .raw(PIN_IN[23:16]),
      .level_reg(pin_val[23:16])
   );

   ppm_sync #(
      .W(8)
   ) p4_sync_inst (
      .clk(CORE_CLK),
      .rst(RST),
      .raw(PIN_IN[31:24]),
      .level_reg(pin_val[31:24])
   );

   ppm_sync #(
      .W(8)
   ) p5_sync_inst (
      .clk(CORE_CLK),
      .rst(RST),
      .raw(PIN_IN[39:32]),
      .level_reg(pin_val[39:32])
   );

   ppm_sync #(
      .W(8)
   ) p6_sync_inst (
      .clk(CORE_CLK),
      .rst(RST),
      .raw(PIN_IN[47:40]),
      .level_reg(pin_val[47:40])
   );

   ppm_sync #(
      .W(8)
   ) p7_sync_inst (
      .clk(CORE_CLK),
      .rst(RST),
      .raw(PIN_IN[55:48]),
      .level_reg(pin_val[55:48])
   );

   wire wr = REG_WR | REG_BIT_WR;

   always @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         p2_latch_reg <= `PPM_RST_LATCH;
         p3_latch_reg <= `PPM_RST_LATCH;
         p4_latch_reg <= `PPM_RST_LATCH;
         p5_latch_reg <= `PPM_RST_LATCH;
         p6_latch_reg <= `PPM_RST_LATCH;
         p7_latch_reg <= `PPM_RST_LATCH;
         p1_drive_reg <= `PPM_RST_DRIVE;
         p2_drive_reg <= `PPM_RST_DRIVE;
         p3_drive_reg <= `PPM_RST_DRIVE;
         p4_drive_reg <= `PPM_RST_DRIVE;
         p5_drive_reg <= `PPM_RST_DRIVE;
         p6_drive_reg <= `PPM_RST_DRIVE;
         p7_drive_reg <= `PPM_RST_DRIVE;
         p1_inpath_reg <= `PPM_RST_INPATH;
         p2_inpath_reg <= `PPM_RST_INPATH;
         p3_inpath_reg <= `PPM_RST_INPATH;
         ctrl_reg <= `PPM_RST_CTRL;
      end else if (wr) begin
         // port 2 and 3 latches answer on every page
         if (REG_ADDR == `PPM_OFS_P2_LATCH) p2_latch_reg <= merge(p2_latch_reg, REG_WDATA, REG_BIT_WR, REG_BIT_SEL);
         if (REG_ADDR == `PPM_OFS_P3_LATCH) p3_latch_reg <= merge(p3_latch_reg, REG_WDATA, REG_BIT_WR, REG_BIT_SEL);
         if (PAGE_F) begin
            case (REG_ADDR)
               `PPM_OFS_P4_LATCH: p4_latch_reg <= merge(p4_latch_reg, REG_WDATA, REG_BIT_WR, REG_BIT_SEL);
               `PPM_OFS_P5_LATCH: p5_latch_reg <= merge(p5_latch_reg, REG_WDATA, REG_BIT_WR, REG_BIT_SEL);
               `PPM_OFS_P6_LATCH: p6_latch_reg <= merge(p6_latch_reg, REG_WDATA, REG_BIT_WR, REG_BIT_SEL);
               `PPM_OFS_P7_LATCH: p7_latch_reg <= merge(p7_latch_reg, REG_WDATA, REG_BIT_WR, REG_BIT_SEL);
               `PPM_OFS_P1_DRIVE: p1_drive_reg <= REG_WDATA;
               `PPM_OFS_P2_DRIVE: p2_drive_reg <= REG_WDATA;
               `PPM_OFS_P3_DRIVE: p3_drive_reg <= REG_WDATA;
               `PPM_OFS_P4_DRIVE: p4_drive_reg <= REG_WDATA;
               `PPM_OFS_P5_DRIVE: p5_drive_reg <= REG_WDATA;
               `PPM_OFS_P6_DRIVE: p6_drive_reg <= REG_WDATA;
               `PPM_OFS_P7_DRIVE: p7_drive_reg <= REG_WDATA;
               `PPM_OFS_P1_INPATH: p1_inpath_reg <= REG_WDATA;
               `PPM_OFS_P2_INPATH: p2_inpath_reg <= REG_WDATA;
               `PPM_OFS_P3_INPATH: p3_inpath_reg <= REG_WDATA;
               `PPM_OFS_CTRL: ctrl_reg <= REG_WDATA;
               default: ctrl_reg <= ctrl_reg;
            endcase
         end
      end
   end

   // read mux: pins normally, latch during read-modify-write
   always @* begin
      rdata_next = 8'h00;
      if (REG_RD) begin
         if (REG_ADDR == `PPM_OFS_P2_LATCH) rdata_next = REG_RMW ? p2_latch_reg : pin_read[15:8];
         else if (REG_ADDR == `PPM_OFS_P3_LATCH) rdata_next = REG_RMW ? p3_latch_reg : pin_read[23:16];
         else if (PAGE_F) begin
            case (REG_ADDR)
               `PPM_OFS_P4_LATCH: rdata_next = REG_RMW ? p4_latch_reg : pin_read[31:24];
               `PPM_OFS_P5_LATCH: rdata_next = REG_RMW ? p5_latch_reg : pin_read[39:32];
               `PPM_OFS_P6_LATCH: rdata_next = REG_RMW ? p6_latch_reg : pin_read[47:40];
               `PPM_OFS_P7_LATCH: rdata_next = REG_RMW ? p7_latch_reg : pin_read[55:48];
               `PPM_OFS_P1_DRIVE: rdata_next = p1_drive_reg;
               `PPM_OFS_P2_DRIVE: rdata_next = p2_drive_reg;
               `PPM_OFS_P3_DRIVE: rdata_next = p3_drive_reg;
               `PPM_OFS_P4_DRIVE: rdata_next = p4_drive_reg;
               `PPM_OFS_P5_DRIVE: rdata_next = p5_drive_reg;
               `PPM_OFS_P6_DRIVE: rdata_next = p6_drive_reg;
               `PPM_OFS_P7_DRIVE: rdata_next = p7_drive_reg;
               `PPM_OFS_P1_INPATH: rdata_next = p1_inpath_reg;
               `PPM_OFS_P2_INPATH: rdata_next = p2_inpath_reg;
               `PPM_OFS_P3_INPATH: rdata_next = p3_inpath_reg;
               `PPM_OFS_CTRL: rdata_next = ctrl_reg;
               default: rdata_next = 8'h00;
            endcase
         end
      end
   end

   // output drive; port 1 latch lives elsewhere, so its pins only float here
   always @* begin
      // memory interface overrides the latch on ports 2 and 3
      p2_src = EMIF_MUXED ? EMIF_ADDR[15:8] : EMIF_ADDR[7:0];
      // both modes: the interface puts only EMIF_DATA on this byte, never address
      p3_src = EMIF_DATA;
      drv_val = {p7_latch_reg, p6_latch_reg, p5_latch_reg, p4_latch_reg, p3_latch_reg, p2_latch_reg, 8'hFF};
      for (i = 0; i < 16; i = i + 1) begin
         if (XBAR_P2_P3_ALLOC[i]) drv_val[8 + i] = PERIPH_P2_P3_OUT[i];
      end
      if (EMIF_ACTIVE) begin
         drv_val[15:8] = p2_src;
         drv_val[23:16] = EMIF_DATA_OE ? p3_src : 8'hFF;
      end
      od_mode = ~{p7_drive_reg, p6_drive_reg, p5_drive_reg, p4_drive_reg, p3_drive_reg, p2_drive_reg, p1_drive_reg};
      od_mode[23:8] = od_mode[23:8] | PERIPH_FORCE_OD;
      if (EMIF_ACTIVE && !EMIF_DATA_OE) od_mode[23:16] = 8'hFF;
      drive_low = ~drv_val;
      // low drives; high drives only in push-pull; otherwise float
      oe_n_next = ~(drive_low | (drv_val & ~od_mode));
      // a push-pull bit must not drive a pin whose latch sits elsewhere
      oe_n_next[7:0] = 8'hFF;
      pu_next = dig_en & ~drive_low & {56{~ctrl_reg[`PPM_CTRL_PUD_BIT]}};
   end

   always @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         REG_RDATA <= 8'h00;
         PIN_OUT <= 56'hFF_FFFF_FFFF_FFFF;
         PIN_OE_N <= 56'hFF_FFFF_FFFF_FFFF;
         PIN_PULLUP_EN <= 56'h00_0000_0000_0000;
         P1_ANALOG_SEL <= 8'h00;
      end else begin
         REG_RDATA <= rdata_next;
         PIN_OUT <= drv_val;
         PIN_OE_N <= oe_n_next;
         PIN_PULLUP_EN <= pu_next;
         P1_ANALOG_SEL <= ~p1_inpath_reg;
      end
   end
endmodule

// three-stage sync; a change counts when stages two and three agree
module ppm_sync #(
   parameter W = 8
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // raw pins and settled level
   input wire [W-1:0] raw,
   output reg [W-1:0] level_reg
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;
   integer k;

   // a pin that flips every edge never settles, so it keeps its last level
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= {W{1'h0}};
         s2_reg <= {W{1'h0}};
         s3_reg <= {W{1'h0}};
         level_reg <= {W{1'h0}};
      end else begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (k = 0; k < W; k = k + 1) begin
            if (s2_reg[k] == s3_reg[k]) begin
               level_reg[k] <= s3_reg[k];
            end
         end
      end
   end
endmodule

// ---- logic/ppm_defs.vh ----
// Purpose: constants for the port pin mode and data control block
// Assumes: 8-bit register port, page F selected by a plain input
// Notes: offsets are register-page addresses; high-port drive offsets chosen here
`ifndef PPM_DEFS_VH
`define PPM_DEFS_VH
`define PPM_OFS_P2_LATCH 8'hA0
`define PPM_OFS_P1_DRIVE 8'hA5
`define PPM_OFS_P2_DRIVE 8'hA6
`define PPM_OFS_P3_DRIVE 8'hA7
`define PPM_OFS_P1_INPATH 8'hAD
`define PPM_OFS_P2_INPATH 8'hAE
`define PPM_OFS_P3_INPATH 8'hAF
`define PPM_OFS_P3_LATCH 8'hB0
`define PPM_OFS_P4_LATCH 8'hC8
`define PPM_OFS_P5_LATCH 8'hD8
`define PPM_OFS_P6_LATCH 8'hE8
`define PPM_OFS_P7_LATCH 8'hF8
`define PPM_OFS_P4_DRIVE 8'h9C
`define PPM_OFS_P5_DRIVE 8'h9D
`define PPM_OFS_P6_DRIVE 8'h9E
`define PPM_OFS_P7_DRIVE 8'h9F
`define PPM_OFS_CTRL 8'hE3
`define PPM_CTRL_PUD_BIT 7
`define PPM_RST_LATCH 8'hFF
`define PPM_RST_DRIVE 8'h00
`define PPM_RST_INPATH 8'hFF
`define PPM_RST_CTRL 8'h00
`endif

// ---- tb/ppm_chk.sv ----
// Purpose: checker on the port control block ports
// Assumes: single clock, async RST
// Notes: pin outputs trail a register write by two edges
module ppm_chk (
   // clock and register port
   input wire CORE_CLK,
   input wire RST,
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   input wire PAGE_F,
   input wire [7:0] REG_RDATA,
   // pins
   input wire [55:0] PIN_OUT,
   input wire [55:0] PIN_OE_N,
   input wire [55:0] PIN_PULLUP_EN,
   input wire [7:0] P1_ANALOG_SEL
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);
   wire pud_wr = REG_WR && PAGE_F && REG_ADDR == 8'hE3;
   wire [7:0] p4_low = ~PIN_OE_N[31:24] & ~PIN_OUT[31:24];
   chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
      else $error("read data outside answer cycle");
   chk_unmapped_zero: assert property (REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   chk_offpage_zero: assert property (REG_RD && !PAGE_F && REG_ADDR == 8'hA6 |=> REG_RDATA == 8'h00)
      else $error("off-page read not zero");
   chk_pud_all_off: assert property (pud_wr && REG_WDATA[7] |-> ##2 PIN_PULLUP_EN == 56'h0)
      else $error("pullups left on");
   chk_pud_cleared: assert property (pud_wr && !REG_WDATA[7] |-> ##2 PIN_PULLUP_EN[31:24] == ~p4_low)
      else $error("pullups not restored");
   chk_low_no_pull: assert property ((~PIN_OE_N & ~PIN_OUT & PIN_PULLUP_EN) == 56'h0)
      else $error("pullup on a low driven pin");
   chk_analog_no_pull: assert property ((P1_ANALOG_SEL & PIN_PULLUP_EN[7:0]) == 8'h00)
      else $error("pullup on analog pin");
   chk_p1_undriven: assert property (PIN_OE_N[7:0] == 8'hFF)
      else $error("port1 pin driven");
endmodule
bind ppm_port_ctrl ppm_chk ppm_chk_inst (
   .CORE_CLK(CORE_CLK),
   .RST(RST),
   .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR),
   .REG_RD(REG_RD),
   .PAGE_F(PAGE_F),
   .REG_RDATA(REG_RDATA),
   .PIN_OUT(PIN_OUT),
   .PIN_OE_N(PIN_OE_N),
   .PIN_PULLUP_EN(PIN_PULLUP_EN),
   .P1_ANALOG_SEL(P1_ANALOG_SEL)
);

// ---- tb/ppm_pins.sv ----
// Purpose: board-side model of the port pins
// Assumes: bench pulls chosen pins low from outside
// Notes: undriven pins without pullup or outside pull-down toggle every edge, so the sync never settles them and holds their last level
module ppm_pins (
   // clock
   input wire clk,
   // device and bench side
   input wire [55:0] drv,
   input wire [55:0] oe_n,
   input wire [55:0] pull,
   input wire [55:0] ext_low,
   output wire [55:0] level
);
   timeunit 1ns;
   timeprecision 100ps;
   logic tog = 1'b0;
   always @(posedge clk) tog <= ~tog;
   // device wins, then outside pull-down, then weak pull
   assign level = (~oe_n & drv) | (oe_n & ~ext_low & (pull | {56{tog}}));
endmodule

// ---- tb/tb_ppm_port_ctrl.sv ----
// Purpose: self-checking bench for the port control block
// Assumes: read data stands only in the cycle after the strobe
// Notes: pin reads lag up to four cycles, eight are allowed
module tb_ppm_port_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   logic CORE_CLK = 1'b0, RST = 1'b1, PAGE_F = 1'b1;
   logic REG_WR = 1'b0, REG_RD = 1'b0, REG_RMW = 1'b0, REG_BIT_WR = 1'b0;
   logic EMIF_ACTIVE = 1'b0, EMIF_MUXED = 1'b0, EMIF_DATA_OE = 1'b0;
   logic [2:0] REG_BIT_SEL = 3'h3;
   logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, EMIF_DATA = 8'h5A;
   logic [15:0] XBAR_P2_P3_ALLOC = 16'h0000, PERIPH_P2_P3_OUT = 16'h0000, PERIPH_FORCE_OD = 16'h0000;
   logic [15:0] EMIF_ADDR = 16'hC3A5;
   logic [55:0] ext_low = 56'h0;
   wire [55:0] PIN_IN, PIN_OUT, PIN_OE_N, PIN_PULLUP_EN;
   wire [7:0] REG_RDATA, P1_ANALOG_SEL;
   int fails = 0, num_checks = 0;
   ppm_port_ctrl ppm_port_ctrl_inst (
      .CORE_CLK(CORE_CLK),
      .RST(RST),
      .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR),
      .REG_RD(REG_RD),
      .REG_RMW(REG_RMW),
      .REG_BIT_WR(REG_BIT_WR),
      .REG_BIT_SEL(REG_BIT_SEL),
      .PAGE_F(PAGE_F),
      .REG_RDATA(REG_RDATA),
      .XBAR_P2_P3_ALLOC(XBAR_P2_P3_ALLOC),
      .PERIPH_P2_P3_OUT(PERIPH_P2_P3_OUT),
      .PERIPH_FORCE_OD(PERIPH_FORCE_OD),
      .EMIF_ACTIVE(EMIF_ACTIVE),
      .EMIF_MUXED(EMIF_MUXED),
      .EMIF_ADDR(EMIF_ADDR),
      .EMIF_DATA(EMIF_DATA),
      .EMIF_DATA_OE(EMIF_DATA_OE),
      .PIN_IN(PIN_IN),
      .PIN_OUT(PIN_OUT),
      .PIN_OE_N(PIN_OE_N),
      .PIN_PULLUP_EN(PIN_PULLUP_EN),
      .P1_ANALOG_SEL(P1_ANALOG_SEL)
   );
   ppm_pins ppm_pins_inst (.clk(CORE_CLK), .drv(PIN_OUT), .oe_n(PIN_OE_N), .pull(PIN_PULLUP_EN), .ext_low(ext_low),
      .level(PIN_IN));
   initial begin
      forever #2 CORE_CLK = ~CORE_CLK;
   end
   task automatic ck(input string nm, input logic [55:0] e, input logic [55:0] g);
      num_checks++;
      if (e !== g) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0);
      @(posedge CORE_CLK);
      {REG_ADDR, REG_WDATA, REG_WR, REG_BIT_WR} <= {a, d, ~b, b};
      @(posedge CORE_CLK);
      {REG_WR, REG_BIT_WR} <= 2'b00;
   endtask
   task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e, input int w = 0);
      repeat (w + 1) @(posedge CORE_CLK);
      {REG_ADDR, REG_RMW, REG_RD} <= {a, m, 1'b1};
      @(posedge CORE_CLK);
      {REG_RMW, REG_RD} <= 2'b00;
      // read data stands until this edge updates it
      @(posedge CORE_CLK);
      ck("read data", 56'(e), 56'(REG_RDATA));
   endtask
   task automatic settle;
      repeat (8) @(posedge CORE_CLK);
   endtask
   task automatic t_regs;
      rd(8'hA0, 1'b1, 8'hFF);
      ck("reset enables", 56'hFF_FFFF_FFFF_FFFF, PIN_OE_N);
      rd(8'hAF, 1'b0, 8'hFF);
      rd(8'h00, 1'b0, 8'h00);
      wr(8'hA6, 8'hFF);
      wr(8'hA0, 8'h5A);
      rd(8'hA0, 1'b1, 8'h5A);
      rd(8'hA0, 1'b0, 8'h5A, 8);
      PAGE_F <= 1'b0;
      wr(8'hA6, 8'h00);
      rd(8'hA6, 1'b0, 8'h00);
      rd(8'hB0, 1'b1, 8'hFF);
      PAGE_F <= 1'b1;
      rd(8'hA6, 1'b0, 8'hFF);
   endtask
   task automatic t_modes;
      wr(8'hA6, 8'h00);
      wr(8'hA0, 8'h0F);
      ext_low[8] <= 1'b1;
      rd(8'hA0, 1'b0, 8'h0E, 8);
      ck("port2 enables", 56'h000F, 56'(PIN_OE_N[15:8]));
      ext_low[8] <= 1'b0;
      wr(8'hAE, 8'hF3);
      wr(8'hAD, 8'h0F);
      wr(8'hA5, 8'hFF);
      rd(8'hA0, 1'b0, 8'h03, 8);
      ck("pullups and analog", 56'h03F0, 56'({PIN_PULLUP_EN[15:8], P1_ANALOG_SEL}));
      ck("port1 floats", 56'h00FF, 56'(PIN_OE_N[7:0]));
   endtask
   task automatic t_pull;
      wr(8'hE3, 8'h80);
      settle();
      ck("all pullups", 56'h0, PIN_PULLUP_EN);
      wr(8'hE3, 8'h00);
      wr(8'hC8, 8'h00, 1'b1);
      rd(8'hC8, 1'b1, 8'hF7);
      rd(8'hC8, 1'b0, 8'hF7, 8);
      ck("port4 pullups", 56'h00F7, 56'(PIN_PULLUP_EN[31:24]));
      wr(8'hD8, 8'h00);
      rd(8'hD8, 1'b0, 8'h00, 8);
   endtask
   task automatic t_xbar;
      wr(8'hA6, 8'hFF);
      wr(8'hA0, 8'h00);
      {XBAR_P2_P3_ALLOC, PERIPH_P2_P3_OUT, PERIPH_FORCE_OD} <= {3{16'h0001}};
      settle();
      ck("forced open drain", 56'h0001, 56'(PIN_OE_N[15:8]));
      wr(8'hA0, 8'hFF);
      PERIPH_P2_P3_OUT <= 16'h0000;
      settle();
      ck("peripheral owns pin", 56'h0000, 56'({PIN_OE_N[8], PIN_OUT[8]}));
      ck("push-pull drives", 56'h0000, 56'(PIN_OE_N[15:8]));
      XBAR_P2_P3_ALLOC <= 16'h0000;
   endtask
   task automatic t_emif;
      {EMIF_ACTIVE, EMIF_MUXED} <= 2'b11;
      settle();
      ck("muxed address", 56'h00C3, 56'(PIN_OUT[15:8]));
      {EMIF_MUXED, EMIF_DATA_OE} <= 2'b01;
      settle();
      ck("address and data", 56'hA55A, 56'({PIN_OUT[15:8], PIN_OUT[23:16]}));
      EMIF_DATA_OE <= 1'b0;
      settle();
      ck("data bus floated", 56'h00FF, 56'(PIN_OE_N[23:16]));
      EMIF_ACTIVE <= 1'b0;
   endtask
   task automatic results;
      if (fails == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge CORE_CLK);
      RST <= 1'b0;
      t_regs();
      t_modes();
      t_pull();
      t_xbar();
      t_emif();
      results();
   end
   initial begin
      repeat (3000) @(posedge CORE_CLK);
      fails++;
      results();
   end
endmodule
